// File: hdl/source_switch_supervisor.sv
// Purpose: digital control core of a dual-battery charger and source selector
// Assumes: hclk 125 MHz; hresetn driven by supply lockout; AHB-Lite registers
// Notes:   comparators are asynchronous pins; outputs drive analog switch drivers
//
// Implementation choices: the AHB-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "switch_params.svh"
module source_switch_supervisor #(
  parameter int TICK_CYCLES     = `TICK_CYCLES,
  parameter int RESTORE_MS      = `RESTORE_TIME_MS,
  parameter int POWERUP_MS      = `POWERUP_TIME_MS,
  parameter int SLOW_MS         = `SLOW_BIT_TIME_MS,
  parameter int FAULT_MS        = `FAULT_TIME_MS
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        load_low_comparator,
  input  wire logic        short_circuit_comparator,
  input  wire logic        load_under_3v_comparator,
  input  wire logic        fast_off_input,
  output logic [2:0]       switch_on,
  output logic [1:0]       charge_enable,
  output logic [1:0]       monitor_select,
  output logic             voltage_setpoint_modulator,
  output logic             current_setpoint_modulator
);
  localparam logic [7:0] ADDR_SELECT  = `OFS_SELECT;
  localparam logic [7:0] ADDR_CHARGE  = `OFS_CHARGE;
  localparam logic [7:0] ADDR_VSET    = `OFS_VSET;
  localparam logic [7:0] ADDR_ISET    = `OFS_ISET;
  localparam logic [7:0] ADDR_STATUS  = `OFS_STATUS;
  localparam int         RESTORE_TICKS = RESTORE_MS;
  localparam int         SLOW_CYCLES   = SLOW_MS * TICK_CYCLES;

  // bus address phase capture
  logic        ph_write;
  logic [7:0]  ph_addr;
  logic        next_ph_write;
  logic [7:0]  next_ph_addr;
  logic [31:0] next_hrdata;

  // software registers
  logic [2:0]  source_select_bits;
  logic [1:0]  battery_charge_select;
  logic [10:0] vset_value;
  logic [9:0]  iset_value;
  logic        low_current_select;
  logic [2:0]  next_sel;
  logic [1:0]  next_chg;
  logic [10:0] next_vset;
  logic [9:0]  next_iset;
  logic        next_low;
  logic        sel_write;
  logic        chg_write;

  // supervisor state
  switch_pkg::path_state_e state;
  switch_pkg::path_state_e next_state;
  logic [1:0]  fail_count;
  logic [1:0]  next_fail_count;
  logic        power_fail_flag;
  logic        next_power_fail_flag;
  logic        fault_flag;
  logic        next_fault_flag;
  logic        fast_off_seen;
  logic        next_fast_off_seen;
  logic        charge_blocked;
  logic        next_charge_blocked;
  logic [10:0] wait_ms;
  logic [10:0] next_wait_ms;
  logic [2:0]  next_switch_on;

  // prescaler and slow step
  logic [31:0] tick_cnt;
  logic [31:0] next_tick_cnt;
  logic        tick;
  logic [31:0] slow_cnt;
  logic [31:0] next_slow_cnt;
  logic        slow_step;
  logic [2:0]  phase;
  logic        iset_bit;
  logic        next_current_out;

  // comparator conditioning
  logic ll_level;
  logic sc_expired;
  logic lv_expired;
  logic fo_level;
  logic ll_prev;
  logic ll_rise;

  sync_timer #(.CW(10)) u_ll (
    .hclk(hclk), .hresetn(hresetn), .raw_in(load_low_comparator), .tick(tick),
    .hold_ms(10'(FAULT_MS)), .level(ll_level), .expired());
  sync_timer #(.CW(10)) u_sc (
    .hclk(hclk), .hresetn(hresetn), .raw_in(short_circuit_comparator), .tick(tick),
    .hold_ms(10'(FAULT_MS)), .level(), .expired(sc_expired));
  sync_timer #(.CW(10)) u_lv (
    .hclk(hclk), .hresetn(hresetn), .raw_in(load_under_3v_comparator), .tick(tick),
    .hold_ms(10'(FAULT_MS)), .level(), .expired(lv_expired));
  sync_timer #(.CW(10)) u_fo (
    .hclk(hclk), .hresetn(hresetn), .raw_in(fast_off_input), .tick(tick),
    .hold_ms(10'(FAULT_MS)), .level(fo_level), .expired());

  assign ll_rise   = ll_level && !ll_prev;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // bus slave
  always_comb begin
    next_ph_write = 1'b0;
    next_ph_addr  = ph_addr;
    next_hrdata   = hrdata;
    next_sel      = source_select_bits;
    next_chg      = battery_charge_select;
    next_vset     = vset_value;
    next_iset     = iset_value;
    next_low      = low_current_select;
    sel_write     = 1'b0;
    chg_write     = 1'b0;
    if (hsel && hready && htrans[1]) begin
      next_ph_write = hwrite;
      next_ph_addr  = haddr[7:0];
      if (!hwrite) begin
        case (haddr[7:0])
          ADDR_SELECT: next_hrdata = {29'h0, source_select_bits};
          ADDR_CHARGE: next_hrdata = {30'h0, battery_charge_select};
          ADDR_VSET:   next_hrdata = {21'h0, vset_value};
          ADDR_ISET:   next_hrdata = {21'h0, low_current_select, iset_value};
          ADDR_STATUS: next_hrdata = {26'h0, fast_off_seen, charge_blocked,
                                      fail_count, fault_flag, power_fail_flag};
          default:     next_hrdata = 32'h0000_0000;
        endcase
      end
    end
    if (ph_write) begin
      case (ph_addr)
        ADDR_SELECT: begin
          next_sel  = hwdata[2:0];
          sel_write = 1'b1;
        end
        ADDR_CHARGE: begin
          next_chg  = hwdata[1:0];
          chg_write = 1'b1;
        end
        ADDR_VSET: next_vset = hwdata[10:0];
        ADDR_ISET: begin
          next_iset = hwdata[9:0];
          next_low  = hwdata[10];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_write              <= 1'b0;
      ph_addr               <= 8'h00;
      hrdata                <= 32'h0000_0000;
      source_select_bits    <= `SEL_RESET;
      battery_charge_select <= 2'h0;
      vset_value            <= 11'h000;
      iset_value            <= 10'h000;
      low_current_select    <= 1'b0;
    end else begin
      ph_write              <= next_ph_write;
      ph_addr               <= next_ph_addr;
      hrdata                <= next_hrdata;
      source_select_bits    <= next_sel;
      battery_charge_select <= next_chg;
      vset_value            <= next_vset;
      iset_value            <= next_iset;
      low_current_select    <= next_low;
    end
  end

  // prescaler: one-ms tick and slow step
  always_comb begin
    tick          = (tick_cnt == 32'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? 32'h0000_0000 : tick_cnt + 32'h0000_0001;
    slow_step     = (slow_cnt == 32'(SLOW_CYCLES - 1));
    next_slow_cnt = slow_step ? 32'h0000_0000 : slow_cnt + 32'h0000_0001;
  end

  // switch sequencer
  always_comb begin
    next_state           = state;
    next_fail_count      = fail_count;
    next_power_fail_flag = power_fail_flag;
    next_fault_flag      = fault_flag;
    next_fast_off_seen   = fast_off_seen;
    next_charge_blocked  = charge_blocked;
    next_wait_ms         = wait_ms;
    next_switch_on       = switch_on;
    if (sel_write) begin
      next_fail_count = 2'h0;
    end
    if (chg_write && !fault_flag) begin
      next_charge_blocked = 1'b0;
    end
    case (state)
      switch_pkg::st_startup: begin
        next_switch_on = `SEL_ALL_OFF;
        if (tick) begin
          next_wait_ms = wait_ms + 11'h001;
        end
        if (wait_ms == 11'(POWERUP_MS)) begin
          next_switch_on = `SEL_ALL_ON;
          next_state     = switch_pkg::st_normal;
        end
      end
      switch_pkg::st_normal: begin
        next_switch_on = source_select_bits;
        if (ll_rise && source_select_bits != `SEL_ALL_OFF) begin
          next_switch_on = `SEL_ALL_ON;
          next_wait_ms   = 11'h000;
          next_state     = switch_pkg::st_all_on;
          if (fail_count != `FAIL_LIMIT) begin
            next_fail_count = fail_count + 2'h1;
          end
          if (fail_count == `FAIL_LIMIT - 2'h1) begin
            next_power_fail_flag = 1'b1;
          end
        end
      end
      switch_pkg::st_all_on: begin
        next_switch_on = `SEL_ALL_ON;
        if (tick) begin
          next_wait_ms = wait_ms + 11'h001;
        end
        if (power_fail_flag) begin
          if (sel_write) begin
            next_power_fail_flag = 1'b0;
            next_state           = switch_pkg::st_normal;
          end
        end else if (wait_ms == 11'(RESTORE_TICKS)) begin
          next_state = switch_pkg::st_normal;
        end
      end
      switch_pkg::st_off: begin
        next_switch_on = `SEL_ALL_OFF;
      end
      default: next_state = switch_pkg::st_off;
    endcase
    if (state != switch_pkg::st_startup) begin
      if (sc_expired || lv_expired) begin
        next_fault_flag     = 1'b1;
        next_charge_blocked = 1'b1;
        next_switch_on      = `SEL_ALL_OFF;
        next_state          = switch_pkg::st_off;
      end
      if (fo_level) begin
        next_fault_flag      = 1'b1;
        next_power_fail_flag = 1'b1;
        next_fast_off_seen   = 1'b1;
        next_charge_blocked  = 1'b1;
        next_switch_on       = `SEL_ALL_OFF;
        next_state           = switch_pkg::st_off;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state           <= switch_pkg::st_startup;
      fail_count      <= 2'h0;
      power_fail_flag <= 1'b0;
      fault_flag      <= 1'b0;
      fast_off_seen   <= 1'b0;
      charge_blocked  <= 1'b0;
      wait_ms         <= 11'h000;
      switch_on       <= `SEL_ALL_OFF;
      tick_cnt        <= 32'h0000_0000;
      slow_cnt        <= 32'h0000_0000;
      ll_prev         <= 1'b0;
    end else begin
      state           <= next_state;
      fail_count      <= next_fail_count;
      power_fail_flag <= next_power_fail_flag;
      fault_flag      <= next_fault_flag;
      fast_off_seen   <= next_fast_off_seen;
      charge_blocked  <= next_charge_blocked;
      wait_ms         <= next_wait_ms;
      switch_on       <= next_switch_on;
      tick_cnt        <= next_tick_cnt;
      slow_cnt        <= next_slow_cnt;
      ll_prev         <= ll_level;
    end
  end

  // setpoint modulators
  ds_mod #(.W(11)) u_vset (
    .hclk(hclk), .hresetn(hresetn), .step(1'b1), .value(vset_value), .full(`VSET_FULL),
    .bit_out(voltage_setpoint_modulator));
  ds_mod #(.W(10)) u_iset (
    .hclk(hclk), .hresetn(hresetn), .step(low_current_select ? slow_step : 1'b1),
    .value(iset_value), .full(`ISET_FULL), .bit_out(iset_bit));

  always_comb begin
    if (low_current_select) begin
      next_current_out = iset_bit && (phase == `LOW_DUTY_ON);
    end else begin
      next_current_out = iset_bit;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase                      <= 3'h0;
      current_setpoint_modulator <= 1'b0;
      charge_enable              <= 2'h0;
      monitor_select             <= 2'h0;
    end else begin
      phase                      <= phase + 3'h1;
      current_setpoint_modulator <= next_current_out;
      if (fault_flag || charge_blocked) begin
        charge_enable <= 2'h0;
      end else if (low_current_select && battery_charge_select == 2'h3) begin
        charge_enable <= 2'h1;
      end else begin
        charge_enable <= battery_charge_select;
      end
      monitor_select <= (low_current_select && battery_charge_select == 2'h3)
                        ? 2'h1 : battery_charge_select;
    end
  end
endmodule : source_switch_supervisor
`default_nettype wire

// File: hdl/switch_params.svh
// Purpose: constants of the source switch supervisor
// Assumes: hclk at 125 MHz, 8 ns period
// Notes:   times in their own unit, cycle counts derived from them
`ifndef SWITCH_PARAMS_SVH
`define SWITCH_PARAMS_SVH
`define CLK_PERIOD_NS      8
`define MS_NS              1000000
`define TICK_CYCLES        (`MS_NS / `CLK_PERIOD_NS)
`define FAULT_TIME_MS      15
`define RESTORE_TIME_MS    1000
`define POWERUP_TIME_MS    250
`define SLOW_BIT_TIME_MS   40
`define FAIL_LIMIT         2'h3
`define SEL_ALL_ON         3'h7
`define SEL_ALL_OFF        3'h0
`define SEL_RESET          3'h7
`define VSET_FULL          11'h07ff
`define ISET_FULL          10'h03ff
`define OFS_SELECT         8'h00
`define OFS_CHARGE         8'h04
`define OFS_VSET           8'h08
`define OFS_ISET           8'h0c
`define OFS_STATUS         8'h10
`define LOW_DUTY_ON        3'h0
`endif

// File: hdl/switch_pkg.sv
// Purpose: shared types of the source switch supervisor
// Assumes: nothing
// Notes:   states of the load-low sequencer
package switch_pkg;
  typedef enum logic [1:0] {
    st_startup,
    st_normal,
    st_all_on,
    st_off
  } path_state_e;
endpackage : switch_pkg

// File: hdl/sync_timer.sv
// Purpose: synchroniser plus millisecond hold timer for one comparator
// Assumes: tick is a one-cycle pulse each millisecond
// Notes:   expired rises after level held more than hold_ms ticks
`timescale 1ns/10ps
`default_nettype none
module sync_timer #(
  parameter int CW = 10
) (
  input  wire logic          hclk,
  input  wire logic          hresetn,
  input  wire logic          raw_in,
  input  wire logic          tick,
  input  wire logic [CW-1:0] hold_ms,
  output logic               level,
  output logic               expired
);
  logic          meta;
  logic          next_level;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_expired;

  always_comb begin
    next_level   = meta;
    next_count   = count;
    next_expired = expired;
    if (!level) begin
      next_count   = '0;
      next_expired = 1'b0;
    end else if (tick && !expired) begin
      if (count == hold_ms) begin
        next_expired = 1'b1;
      end else begin
        next_count = count + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta    <= 1'b0;
      level   <= 1'b0;
      count   <= '0;
      expired <= 1'b0;
    end else begin
      meta    <= raw_in;
      level   <= next_level;
      count   <= next_count;
      expired <= next_expired;
    end
  end
endmodule : sync_timer
`default_nettype wire

// File: hdl/ds_mod.sv
// Purpose: first-order delta-sigma modulator
// Assumes: density of bit_out is value / full
// Notes:   advances only on step
`timescale 1ns/10ps
`default_nettype none
module ds_mod #(
  parameter int W = 11
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         step,
  input  wire logic [W-1:0] value,
  input  wire logic [W-1:0] full,
  output logic              bit_out
);
  logic [W:0] acc;
  logic [W:0] next_acc;
  logic [W:0] sum;
  logic       next_bit;

  always_comb begin
    sum      = acc + {1'b0, value};
    next_acc = acc;
    next_bit = bit_out;
    if (step) begin
      if (sum >= {1'b0, full}) begin
        next_acc = sum - {1'b0, full};
        next_bit = 1'b1;
      end else begin
        next_acc = sum;
        next_bit = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc     <= '0;
      bit_out <= 1'b0;
    end else begin
      acc     <= next_acc;
      bit_out <= next_bit;
    end
  end
endmodule : ds_mod
`default_nettype wire

// File: tb/host_model.sv
// Purpose: bus-side controller model driving the register port
// Assumes: one slave, its hreadyout is hready
// Notes:   transfer tasks are called by the bench
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic        hclk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end

  task xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
            output logic [31:0] r);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask : xfer

  // wanted voltage code less the reference offset
  task set_vset(input logic [10:0] code);
    logic [31:0] r;
    xfer(32'h0000_0008, 1'b1, {21'h0, code - 11'h032}, r);
  endtask : set_vset
endmodule : host_model
`default_nettype wire

// File: tb/source_switch_supervisor_chk.sv
// Purpose: port checker of the source switch supervisor
// Assumes: single hclk domain
// Notes:   bound from the bench top
`timescale 1ns/10ps
`default_nettype none
module source_switch_supervisor_chk #(
  parameter int TICK_CYCLES = 10,
  parameter int POWERUP_MS  = 5,
  parameter int FAULT_MS    = 3
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        load_low_comparator,
  input wire logic        short_circuit_comparator,
  input wire logic        load_under_3v_comparator,
  input wire logic        fast_off_input,
  input wire logic [2:0]  switch_on
);
  localparam int LIM = (FAULT_MS + 2) * TICK_CYCLES + 6;
  logic [15:0] up_cnt, sc_cnt, uv_cnt, next_up_cnt, next_sc_cnt, next_uv_cnt;
  logic        rd_taken;
  assign rd_taken = hsel && hready && htrans[1] && !hwrite;

  function automatic logic [15:0] sat(input logic [15:0] c, input logic en);
    return !en ? 16'h0000 : (c == 16'hffff) ? c : c + 16'h0001;
  endfunction : sat

  always_comb begin
    next_up_cnt = sat(up_cnt, 1'b1);
    next_sc_cnt = sat(sc_cnt, short_circuit_comparator);
    next_uv_cnt = sat(uv_cnt, load_under_3v_comparator);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      up_cnt <= 16'h0000;
      sc_cnt <= 16'h0000;
      uv_cnt <= 16'h0000;
    end else begin
      up_cnt <= next_up_cnt;
      sc_cnt <= next_sc_cnt;
      uv_cnt <= next_uv_cnt;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_ready_high: assert property (hreadyout == 1'b1) else $error("slave stalled");
  a_rdata_hold: assert property (!rd_taken |=> $stable(hrdata)) else $error("read data moved");
  a_powerup_off: assert property (up_cnt < (POWERUP_MS - 1) * TICK_CYCLES |->
    switch_on == 3'h0) else $error("switch on too early");
  a_load_low_on: assert property ($rose(load_low_comparator) && switch_on != 3'h0 &&
    !fast_off_input && !short_circuit_comparator && !load_under_3v_comparator
    |-> ##[1:8] switch_on == 3'h7) else $error("no all-on after load low");
  a_allon_hold: assert property ($rose(switch_on == 3'h7) |->
    (switch_on == 3'h7) [*8]) else $error("all-on left early");
  a_short_off: assert property (sc_cnt > LIM |-> switch_on == 3'h0)
    else $error("short not cut off");
  a_under_off: assert property (uv_cnt > LIM |-> switch_on == 3'h0)
    else $error("low load not cut off");
  a_fast_off: assert property (fast_off_input [*4] |-> ##[0:3] switch_on == 3'h0)
    else $error("fast off ignored");
  a_fast_hold: assert property (fast_off_input [*4] ##1 !fast_off_input |->
    (switch_on == 3'h0) [*8]) else $error("switch back after fast off");

  c_load_low: cover property ($rose(load_low_comparator) ##[1:8] switch_on == 3'h7);
  c_short: cover property (sc_cnt > LIM);
  c_fast: cover property (fast_off_input [*4]);
  c_read: cover property (rd_taken);
endmodule : source_switch_supervisor_chk
`default_nettype wire

// File: tb/test_source_switch_supervisor.sv
// Purpose: self-checking bench of the source switch supervisor
// Assumes: shortened tick and timeouts
// Notes:   comp bits: load low, short, under 3 V, fast off
`timescale 1ns/10ps
`default_nettype none
module test_source_switch_supervisor;
  localparam int TICK = 10;
  localparam int REST = 5;
  localparam int PWUP = 5;
  localparam int FLT  = 3;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [3:0]  comp;
  logic [2:0]  switch_on;
  logic [1:0]  charge_enable;
  logic [1:0]  monitor_select;
  logic        vmod;
  logic        imod;
  int          mismatches;
  int          check_count;

  source_switch_supervisor #(.TICK_CYCLES(TICK), .RESTORE_MS(REST), .POWERUP_MS(PWUP),
    .SLOW_MS(2), .FAULT_MS(FLT)) u_source_switch_supervisor (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .load_low_comparator(comp[0]), .short_circuit_comparator(comp[1]),
    .load_under_3v_comparator(comp[2]), .fast_off_input(comp[3]),
    .switch_on(switch_on), .charge_enable(charge_enable), .monitor_select(monitor_select),
    .voltage_setpoint_modulator(vmod), .current_setpoint_modulator(imod));
  host_model u_host_model (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end

  task stop_test;
    $display("mismatches=%0d checks=%0d", mismatches, check_count);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : stop_test

  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task check_range(input int k, input int lo, input int hi);
    check({31'h0, k >= lo && k <= hi}, 32'h1);
  endtask : check_range
  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    u_host_model.xfer(a, 1'b1, d, r);
  endtask : wr
  task rd(input logic [31:0] a, output logic [31:0] r);
    u_host_model.xfer(a, 1'b0, 32'h0000_0000, r);
  endtask : rd
  task wait_sw(input logic [2:0] v, input int lim, output int n);
    n = 0;
    while (switch_on !== v && n < lim) begin
      @(negedge hclk);
      n++;
    end
  endtask : wait_sw
  task count(input bit which, input int n, output int k);
    k = 0;
    repeat (3) @(negedge hclk);
    repeat (n) begin
      @(negedge hclk);
      k += which ? int'(imod === 1'b1) : int'(vmod === 1'b1);
    end
  endtask : count
  task do_reset;
    int n;
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    wait_sw(3'h7, PWUP * TICK + 60, n);
    check(switch_on, 3'h7);
    check_range(n, (PWUP - 1) * TICK, PWUP * TICK + 60);
    repeat (10) @(negedge hclk);
    check(switch_on, 3'h7);
  endtask : do_reset

  task t_select;
    logic [31:0] r;
    for (int i = 0; i < 8; i++) begin
      wr(32'h0000_0000, 32'(i));
      repeat (3) @(negedge hclk);
      check(switch_on, i[2:0]);
    end
    rd(32'h0000_0020, r);
    check(r, 32'h0000_0000);
    wr(32'h0000_0010, 32'hffff_ffff);
    rd(32'h0000_0010, r);
    check(r & 32'h0000_0003, 32'h0000_0000);
    repeat (10) @(posedge hclk);
  endtask : t_select

  task t_load_low;
    logic [31:0] r;
    int n;
    wr(32'h0000_0000, 32'h0000_0003);
    repeat (10) @(posedge hclk);
    for (int i = 1; i <= 3; i++) begin
      @(posedge hclk);
      comp[0] <= 1'b1;
      repeat (3) @(posedge hclk);
      comp[0] <= 1'b0;
      wait_sw(3'h7, 20, n);
      check(switch_on, 3'h7);
      rd(32'h0000_0010, r);
      check({30'h0, r[3:2]}, 32'(i));
      check({31'h0, r[0]}, 32'(i == 3));
      wait_sw(3'h3, REST * TICK + 40, n);
      if (i < 3) begin
        check(switch_on, 3'h3);
        check_range(n, (REST - 1) * TICK - 10, REST * TICK + 40);
      end else begin
        check(switch_on, 3'h7);
      end
    end
    wr(32'h0000_0000, 32'h0000_0005);
    rd(32'h0000_0010, r);
    check({30'h0, r[3:2]}, 32'h0000_0000);
    check(switch_on, 3'h5);
  endtask : t_load_low

  task t_dac;
    int k;
    u_host_model.set_vset(11'h0432);
    count(1'b0, 2047, k);
    check_range(k, 1022, 1026);
    wr(32'h0000_000c, 32'h0000_012c);
    count(1'b1, 1023, k);
    check_range(k, 298, 302);
    wr(32'h0000_0004, 32'h0000_0003);
    repeat (3) @(negedge hclk);
    check(monitor_select, 2'h3);
    wr(32'h0000_000c, 32'h0000_07ff);
    repeat (100) @(negedge hclk);
    count(1'b1, 800, k);
    check_range(k, 99, 101);
    check(charge_enable, 2'h1);
    check(monitor_select, 2'h1);
  endtask : t_dac

  task t_fault(input int kind);
    logic [31:0] r;
    int n;
    wr(32'h0000_0004, 32'h0000_0001);
    @(posedge hclk);
    if (kind != 3) begin
      comp[kind] <= 1'b1;
      repeat (25) @(posedge hclk);
      comp[kind] <= 1'b0;
      repeat (5) @(posedge hclk);
    end
    comp[kind] <= 1'b1;
    wait_sw(3'h0, (FLT + 3) * TICK, n);
    check(switch_on, 3'h0);
    if (kind != 3) check_range(n, FLT * TICK, (FLT + 3) * TICK);
    repeat (30) @(posedge hclk);
    comp[kind] <= 1'b0;
    rd(32'h0000_0010, r);
    check({31'h0, r[1]}, 32'h0000_0001);
    if (kind == 3) check({31'h0, r[0]}, 32'h0000_0001);
    wr(32'h0000_0000, 32'h0000_0007);
    wr(32'h0000_0004, 32'h0000_0001);
    repeat (20) @(negedge hclk);
    check(switch_on, 3'h0);
    check(charge_enable, 2'h0);
    rd(32'h0000_0010, r);
    check({31'h0, r[1]}, 32'h0000_0001);
    do_reset;
    rd(32'h0000_0010, r);
    check({31'h0, r[1]}, 32'h0000_0000);
    wr(32'h0000_0004, 32'h0000_0001);
    repeat (3) @(negedge hclk);
    check(charge_enable, 2'h1);
  endtask : t_fault

  initial begin
    hresetn     = 1'b0;
    comp        = 4'h0;
    mismatches  = 0;
    check_count = 0;
    do_reset;
    t_select;
    t_load_low;
    t_dac;
    for (int k = 1; k < 4; k++) t_fault(k);
    stop_test;
  end
  initial begin
    #200000;
    mismatches++;
    stop_test;
  end
endmodule : test_source_switch_supervisor

bind source_switch_supervisor source_switch_supervisor_chk #(.TICK_CYCLES(TICK_CYCLES),
  .POWERUP_MS(POWERUP_MS), .FAULT_MS(FAULT_MS)) u_source_switch_supervisor_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .load_low_comparator(load_low_comparator),
  .short_circuit_comparator(short_circuit_comparator),
  .load_under_3v_comparator(load_under_3v_comparator),
  .fast_off_input(fast_off_input), .switch_on(switch_on));
`default_nettype wire
